// file: common/iolm_pkg.sv
// Package for the I/O line function multiplexer: register offsets, widths, reset values.
// Assumes a 32-pin port reached over a plain strobe register port with byte offsets one word apart.
package iolm_pkg;
	localparam int PIN_COUNT = 32;
	localparam int ADDR_WIDTH = 8;
	localparam int DATA_WIDTH = 32;
	localparam int FUNC_COUNT = 4;

	// Register byte offsets
	localparam logic [ADDR_WIDTH-1:0] TAKEOVER_SET_OFS = 8'h00;
	localparam logic [ADDR_WIDTH-1:0] RELEASE_CLEAR_OFS = 8'h04;
	localparam logic [ADDR_WIDTH-1:0] OWNERSHIP_STATUS_OFS = 8'h08;
	localparam logic [ADDR_WIDTH-1:0] FUNC_SELECT_LOW_OFS = 8'h0C;
	localparam logic [ADDR_WIDTH-1:0] FUNC_SELECT_HIGH_OFS = 8'h10;

	// Reset values
	localparam logic [PIN_COUNT-1:0] OWNERSHIP_RESET = 32'hFFFFFFFF;
	localparam logic [PIN_COUNT-1:0] FUNC_SELECT_RESET = 32'h00000000;
	localparam logic [DATA_WIDTH-1:0] READ_ZERO = 32'h00000000;

	// Function codes, high select bit then low select bit
	typedef enum logic [1:0] {
		FUNC_A = 2'b00,
		FUNC_B = 2'b01,
		FUNC_C = 2'b10,
		FUNC_D = 2'b11
	} iolm_func_e;
endpackage : iolm_pkg

// file: design/iolm_pin_slice.sv
// One pin's output multiplexer: controller drive or the selected peripheral.
// Assumes all inputs are on clk; peripheral inputs are fed from the pin through a two-stage synchroniser elsewhere.
`timescale 1ns/1ps
module iolm_pin_slice
	import iolm_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ownedByCtrl,
	input wire logic selLow,
	input wire logic selHigh,
	input wire logic [FUNC_COUNT-1:0] funcPresent,
	input wire logic [FUNC_COUNT-1:0] funcOut,
	input wire logic [FUNC_COUNT-1:0] funcOeN,
	input wire logic ctrlOut,
	input wire logic ctrlOeN,
	output logic padOut,
	output logic padOeN
);
	logic [1:0] funcIdx;
	logic outNxt;
	logic oeNNxt;

	// Pick the drive source; an absent function leaves the pad undriven
	always_comb begin
		funcIdx = {selHigh, selLow};
		outNxt = ctrlOut;
		oeNNxt = ctrlOeN;
		if (!ownedByCtrl) begin
			if (funcPresent[funcIdx]) begin
				outNxt = funcOut[funcIdx];
				oeNNxt = funcOeN[funcIdx];
			end else begin
				outNxt = 1'b0;
				oeNNxt = 1'b1;
			end
		end
	end

	// Registered pad drive, released at reset so nothing fights the pad
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			padOut <= 1'b0;
			padOeN <= 1'b1;
		end else begin
			padOut <= outNxt;
			padOeN <= oeNNxt;
		end
	end
endmodule : iolm_pin_slice

// file: design/iolm_line_mux.sv
// Top of the I/O line function multiplexer: ownership and function-select registers,
// register port, and one output slice per pin.
// Assumes peripherals and the register master run on clk; pad inputs are asynchronous.
//
// Overview of operation
// - Set/clear writes derive each pin's ownership.
// - Status zero means peripheral, one controller.
// - Pins without peripherals ignore writes, read one.
// - Ownership reset value is a product parameter.
// - Four functions per pin, two select bits.
// - Select low/high bits encode A, B, C, D.
// - Peripheral inputs always see the pin.
// - Select writes take effect in any ownership.
// - Select registers reset to zero, function A.
// - Absent function selected: stored, nothing driven.
// - Peripheral-owned pin outputs selected function value.
// - Selected function's enable decides pin drive.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module iolm_line_mux
	import iolm_pkg::*;
#(
	parameter logic [PIN_COUNT-1:0] OWN_RESET = OWNERSHIP_RESET,
	parameter logic [PIN_COUNT-1:0] MUXED_PINS = 32'hFFFFFFFF,
	parameter logic [PIN_COUNT*FUNC_COUNT-1:0] FUNC_MAP = {PIN_COUNT{4'hF}}
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [ADDR_WIDTH-1:0] regAddr,
	input wire logic [DATA_WIDTH-1:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [DATA_WIDTH-1:0] regRdData,
	input wire logic [PIN_COUNT-1:0] ctrlOut,
	input wire logic [PIN_COUNT-1:0] ctrlOeN,
	input wire logic [PIN_COUNT*FUNC_COUNT-1:0] periphOut,
	input wire logic [PIN_COUNT*FUNC_COUNT-1:0] periphOeN,
	output logic [PIN_COUNT-1:0] periphIn,
	input wire logic [PIN_COUNT-1:0] padIn,
	output logic [PIN_COUNT-1:0] padOut,
	output logic [PIN_COUNT-1:0] padOeN
);
	logic [PIN_COUNT-1:0] ownership_r;
	logic [PIN_COUNT-1:0] ownership_nxt;
	logic [PIN_COUNT-1:0] selLow_r;
	logic [PIN_COUNT-1:0] selHigh_r;
	logic [PIN_COUNT-1:0] padSync1_r;
	logic [PIN_COUNT-1:0] padSync2_r;
	logic [DATA_WIDTH-1:0] rdData_nxt;
	logic wrSet;
	logic wrClr;
	logic wrLow;
	logic wrHigh;
	logic [1:0] sinceRst_r;

	// Write decode
	always_comb begin
		wrSet = 1'b0;
		wrClr = 1'b0;
		wrLow = 1'b0;
		wrHigh = 1'b0;
		if (regWrStb && regAddr == TAKEOVER_SET_OFS) begin
			wrSet = 1'b1;
		end else if (regWrStb && regAddr == RELEASE_CLEAR_OFS) begin
			wrClr = 1'b1;
		end else if (regWrStb && regAddr == FUNC_SELECT_LOW_OFS) begin
			wrLow = 1'b1;
		end else if (regWrStb && regAddr == FUNC_SELECT_HIGH_OFS) begin
			wrHigh = 1'b1;
		end
	end

	// Ownership next value; unmuxed pins are pinned to controller-owned
	always_comb begin
		ownership_nxt = ownership_r;
		if (wrSet) begin
			ownership_nxt = ownership_r | regWrData;
		end else if (wrClr) begin
			ownership_nxt = ownership_r & ~regWrData;
		end
		ownership_nxt = ownership_nxt | ~MUXED_PINS;
	end

	// Ownership status; reset value per product, unmuxed pins forced high
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ownership_r <= OWN_RESET | ~MUXED_PINS;
		end else begin
			ownership_r <= ownership_nxt;
		end
	end

	// Function selects are stored unchecked whatever the ownership
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			selLow_r <= FUNC_SELECT_RESET;
			selHigh_r <= FUNC_SELECT_RESET;
		end else begin
			if (wrLow) begin
				selLow_r <= regWrData;
			end
			if (wrHigh) begin
				selHigh_r <= regWrData;
			end
		end
	end

	// Read decode; set/clear registers read as zero
	always_comb begin
		rdData_nxt = READ_ZERO;
		if (regAddr == OWNERSHIP_STATUS_OFS) begin
			rdData_nxt = ownership_r;
		end else if (regAddr == FUNC_SELECT_LOW_OFS) begin
			rdData_nxt = selLow_r;
		end else if (regAddr == FUNC_SELECT_HIGH_OFS) begin
			rdData_nxt = selHigh_r;
		end else begin
			rdData_nxt = READ_ZERO;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdData <= READ_ZERO;
		end else if (regRdStb) begin
			regRdData <= rdData_nxt;
		end else begin
			regRdData <= READ_ZERO;
		end
	end

	// Pad input synchroniser; peripherals see the pin whatever is selected
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			padSync1_r <= FUNC_SELECT_RESET;
			padSync2_r <= FUNC_SELECT_RESET;
		end else begin
			padSync1_r <= padIn;
			padSync2_r <= padSync1_r;
		end
	end

	assign periphIn = padSync2_r;

	// One output slice per pin; absent functions come from the product map
	for (genvar p = 0; p < PIN_COUNT; p++) begin : gPin
		iolm_pin_slice uSlice (
			.clk(clk),
			.arst_n(arst_n),
			.ownedByCtrl(ownership_r[p]),
			.selLow(selLow_r[p]),
			.selHigh(selHigh_r[p]),
			.funcPresent(FUNC_MAP[p*FUNC_COUNT +: FUNC_COUNT]),
			.funcOut(periphOut[p*FUNC_COUNT +: FUNC_COUNT]),
			.funcOeN(periphOeN[p*FUNC_COUNT +: FUNC_COUNT]),
			.ctrlOut(ctrlOut[p]),
			.ctrlOeN(ctrlOeN[p]),
			.padOut(padOut[p]),
			.padOeN(padOeN[p])
		);
	end

	// Status follows set and clear writes one cycle later
	ownSetWrite_a: assert property (@(posedge clk) disable iff (!arst_n)
		wrSet |=> ((ownership_r & $past(regWrData)) == $past(regWrData)))
		else $error("takeover set did not give pin to controller");

	ownClrWrite_a: assert property (@(posedge clk) disable iff (!arst_n)
		wrClr |=> ((ownership_r & $past(regWrData) & MUXED_PINS) == READ_ZERO))
		else $error("release clear did not hand pin to peripheral");

	// Unmuxed pins never leave controller ownership
	unmuxedOwn_a: assert property (@(posedge clk) disable iff (!arst_n)
		((ownership_r | MUXED_PINS) == {PIN_COUNT{1'b1}}))
		else $error("unmuxed pin left controller ownership");

	// Writes to other offsets leave ownership alone
	ownStable_a: assert property (@(posedge clk) disable iff (!arst_n)
		!(wrSet || wrClr) |=> $stable(ownership_r))
		else $error("ownership changed without a set or clear write");

	// Select low reads back the value written; select high takes the written value
	selReadback_a: assert property (@(posedge clk) disable iff (!arst_n)
		(wrLow ##1 (regRdStb && regAddr == FUNC_SELECT_LOW_OFS && !regWrStb))
		|=> (regRdData == $past(regWrData, 2)))
		else $error("select low read back differs from write");

	selUpdate_a: assert property (@(posedge clk) disable iff (!arst_n)
		wrHigh |=> (selHigh_r == $past(regWrData)))
		else $error("select high did not take the written value");

	// Status read returns ownership in the next cycle only
	statusRead_a: assert property (@(posedge clk) disable iff (!arst_n)
		(regRdStb && regAddr == OWNERSHIP_STATUS_OFS && !wrSet && !wrClr)
		|=> (regRdData == $past(ownership_r)) ##1 ($past(regRdStb) || regRdData == READ_ZERO))
		else $error("status read data wrong or held too long");

	// Controller-owned pin follows the controller drive
	ctrlDrive_a: assert property (@(posedge clk) disable iff (!arst_n)
		ownership_r[0] |=> (padOut[0] == $past(ctrlOut[0]) && padOeN[0] == $past(ctrlOeN[0])))
		else $error("controller-owned pin not following controller");

	// Peripheral-owned pin with function present takes that function's enable
	periphDrive_a: assert property (@(posedge clk) disable iff (!arst_n)
		(!ownership_r[0] && FUNC_MAP[{selHigh_r[0], selLow_r[0]}])
		|=> (padOeN[0] == $past(periphOeN[{selHigh_r[0], selLow_r[0]}])))
		else $error("selected peripheral enable not on pin");

	// Edges since reset, so checks on the first cycles know where they stand
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sinceRst_r <= 2'h0;
		end else if (!(&sinceRst_r)) begin
			sinceRst_r <= sinceRst_r + 2'h1;
		end
	end

	// First cycle after reset: product ownership, cleared selects
	rstOwn_a: assert property (@(posedge clk) disable iff (!arst_n)
		(sinceRst_r == 2'h0) |-> (ownership_r == (OWN_RESET | ~MUXED_PINS)))
		else $error("ownership status left reset with the wrong value");

	rstSelect_a: assert property (@(posedge clk) disable iff (!arst_n)
		(sinceRst_r == 2'h0)
		|-> (selLow_r == FUNC_SELECT_RESET && selHigh_r == FUNC_SELECT_RESET))
		else $error("function selects did not reset to function A");

	// Pads leave reset undriven, so function A cannot fight the pin
	rstPad_a: assert property (@(posedge clk) disable iff (!arst_n)
		(sinceRst_r == 2'h0)
		|-> (padOeN == {PIN_COUNT{1'b1}} && regRdData == READ_ZERO))
		else $error("pad driven or read data set straight after reset");

	// Synchroniser starts from zero, so no false pin level reaches peripherals
	rstSync_a: assert property (@(posedge clk) disable iff (!arst_n)
		(sinceRst_r == 2'h0) |-> (periphIn == {PIN_COUNT{1'b0}}))
		else $error("peripheral input not cleared by reset");

	// Read data are zero in any cycle that does not follow a read
	rdIdle_a: assert property (@(posedge clk) disable iff (!arst_n)
		!regRdStb |=> (regRdData == READ_ZERO))
		else $error("read data present without a read strobe");

	// Set and clear words are write-only and read as zero
	wrOnlyRead_a: assert property (@(posedge clk) disable iff (!arst_n)
		(regRdStb && (regAddr == TAKEOVER_SET_OFS || regAddr == RELEASE_CLEAR_OFS))
		|=> (regRdData == READ_ZERO))
		else $error("set or clear word read back nonzero");

	// Anything but status and the selects reads as zero
	rdUnmapped_a: assert property (@(posedge clk) disable iff (!arst_n)
		(regRdStb && regAddr != OWNERSHIP_STATUS_OFS && regAddr != FUNC_SELECT_LOW_OFS
		&& regAddr != FUNC_SELECT_HIGH_OFS) |=> (regRdData == READ_ZERO))
		else $error("unmapped or write-only offset read nonzero");

	// Both selects read back what they hold
	selLowRead_a: assert property (@(posedge clk) disable iff (!arst_n)
		(regRdStb && regAddr == FUNC_SELECT_LOW_OFS) |=> (regRdData == $past(selLow_r)))
		else $error("select low read data differ from the register");

	selHighRead_a: assert property (@(posedge clk) disable iff (!arst_n)
		(regRdStb && regAddr == FUNC_SELECT_HIGH_OFS) |=> (regRdData == $past(selHigh_r)))
		else $error("select high read data differ from the register");

	// Selects change on their own write only, and take the written word
	selLowHold_a: assert property (@(posedge clk) disable iff (!arst_n)
		!wrLow |=> $stable(selLow_r))
		else $error("select low changed without its write");

	selHighHold_a: assert property (@(posedge clk) disable iff (!arst_n)
		!wrHigh |=> $stable(selHigh_r))
		else $error("select high changed without its write");

	selLowUpdate_a: assert property (@(posedge clk) disable iff (!arst_n)
		wrLow |=> (selLow_r == $past(regWrData)))
		else $error("select low did not take the written value");

	// A status read right after a set or clear already shows its effect
	setThenRead_a: assert property (@(posedge clk) disable iff (!arst_n)
		(wrSet ##1 (regRdStb && regAddr == OWNERSHIP_STATUS_OFS))
		|=> ((regRdData & $past(regWrData, 2)) == $past(regWrData, 2)))
		else $error("status read after takeover set shows a peripheral");

	clrThenRead_a: assert property (@(posedge clk) disable iff (!arst_n)
		(wrClr ##1 (regRdStb && regAddr == OWNERSHIP_STATUS_OFS))
		|=> ((regRdData & $past(regWrData, 2) & MUXED_PINS) == READ_ZERO))
		else $error("status read after release clear shows the controller");

	// Every pin's drive against its ownership and selected function
	for (genvar p = 0; p < PIN_COUNT; p++) begin : gPinChk
		logic [1:0] selCode;
		logic funcHere;

		// Selected code, and whether this product fits that function to the pin
		assign selCode = {selHigh_r[p], selLow_r[p]};
		assign funcHere = FUNC_MAP[p*FUNC_COUNT + selCode];

		pinCtrl_a: assert property (@(posedge clk) disable iff (!arst_n)
			ownership_r[p]
			|=> (padOut[p] == $past(ctrlOut[p]) && padOeN[p] == $past(ctrlOeN[p])))
			else $error("controller-owned pin not driven by the controller");

		// Peripheral-owned pin takes value and enable from the selected function
		pinFuncOut_a: assert property (@(posedge clk) disable iff (!arst_n)
			(!ownership_r[p] && funcHere)
			|=> (padOut[p] == $past(periphOut[p*FUNC_COUNT + selCode])))
			else $error("pin value not from the selected function");

		pinFuncOe_a: assert property (@(posedge clk) disable iff (!arst_n)
			(!ownership_r[p] && funcHere)
			|=> (padOeN[p] == $past(periphOeN[p*FUNC_COUNT + selCode])))
			else $error("pin enable not from the selected function");

		// Selected function absent on this pin: stored, but nothing drives
		pinAbsent_a: assert property (@(posedge clk) disable iff (!arst_n)
			(!ownership_r[p] && !funcHere) |=> (padOut[p] == 1'b0 && padOeN[p] == 1'b1))
			else $error("absent function selected yet pin driven");

		// Peripherals see the pin two edges late, whatever is selected
		pinInput_a: assert property (@(posedge clk) disable iff (!arst_n)
			(&sinceRst_r) |-> (periphIn[p] == $past(padIn[p], 2)))
			else $error("peripheral input does not follow the pin");

		// Set and clear act on bits written as one; zero bits leave the pin alone
		pinSet_a: assert property (@(posedge clk) disable iff (!arst_n)
			(wrSet && regWrData[p]) |=> ownership_r[p])
			else $error("takeover set left pin with a peripheral");

		pinClr_a: assert property (@(posedge clk) disable iff (!arst_n)
			(wrClr && regWrData[p] && MUXED_PINS[p]) |=> !ownership_r[p])
			else $error("release clear left pin with the controller");

		pinKeep_a: assert property (@(posedge clk) disable iff (!arst_n)
			((wrSet || wrClr) && !regWrData[p]) |=> $stable(ownership_r[p]))
			else $error("zero bit in set or clear moved the pin");

		// A pin with no peripheral stays with the controller, whatever is written
		pinPlain_a: assert property (@(posedge clk) disable iff (!arst_n)
			!MUXED_PINS[p] |-> ownership_r[p])
			else $error("plain pin reported as peripheral-owned");
	end
endmodule : iolm_line_mux

// file: dv/iolm_periph_model.sv
// Peripheral side model: four function drivers per pin, values and enables.
// Assumes clk is the system clock; drive changes just after each rising edge.
`timescale 1ns/1ps
module iolm_periph_model
	import iolm_pkg::*;
(
	input wire logic clk,
	output logic [PIN_COUNT*FUNC_COUNT-1:0] periphOut,
	output logic [PIN_COUNT*FUNC_COUNT-1:0] periphOeN
);
	integer seed = 32'hDBB1;
	initial begin
		periphOut = '0;
		periphOeN = '1;
	end
	// Fresh values every cycle, so a stale or wrong function never matches by luck
	always @(posedge clk) begin
		periphOut <= {$random(seed), $random(seed), $random(seed), $random(seed)};
		periphOeN <= {$random(seed), $random(seed), $random(seed), $random(seed)};
	end
endmodule : iolm_periph_model

// file: dv/test_io_line_function_mux.sv
// Testbench of the I/O line function multiplexer: registers, ownership, pad muxing.
// Assumes the peripheral model drives the function outputs; the bench is software.
`timescale 1ns/1ps
module test_io_line_function_mux;
	import iolm_pkg::*;
	localparam logic [PIN_COUNT-1:0] MUX = 32'h7FFFFFFF; // Pin 31 plain I/O
	localparam logic [PIN_COUNT-1:0] OWN_RST = 32'hFFFFFFFB; // Pin 2 leaves reset with a peripheral
	localparam logic [PIN_COUNT*FUNC_COUNT-1:0] FMAP = ~128'h80; // Pin 1 lacks function D
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_WIDTH-1:0] regAddr = '0;
	logic [DATA_WIDTH-1:0] regWrData = '0;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic [PIN_COUNT-1:0] ctrlOut = '0;
	logic [PIN_COUNT-1:0] ctrlOeN = '1;
	logic [PIN_COUNT-1:0] padIn = '0;
	logic [DATA_WIDTH-1:0] regRdData, rv;
	logic [PIN_COUNT-1:0] periphIn, padOut, padOeN, expOut, expOeN, own, selLo, selHi, d1, d2;
	logic [PIN_COUNT*FUNC_COUNT-1:0] periphOut, periphOeN;
	logic [7:0] ra;
	integer seed = 32'hDBB1;
	int n_fail = 0;
	int tests_run = 0;
	int up = 0;
	int fc;
	always #2 clk = ~clk;
	iolm_periph_model peer (.clk(clk), .periphOut(periphOut), .periphOeN(periphOeN));
	iolm_line_mux #(.OWN_RESET(OWN_RST), .MUXED_PINS(MUX), .FUNC_MAP(FMAP)) dut (
		.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.ctrlOut(ctrlOut), .ctrlOeN(ctrlOeN), .periphOut(periphOut), .periphOeN(periphOeN),
		.periphIn(periphIn), .padIn(padIn), .padOut(padOut), .padOeN(padOeN));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic [31:0] regVal(input logic [7:0] a);
		case (a)
			OWNERSHIP_STATUS_OFS: return own;
			FUNC_SELECT_LOW_OFS: return selLo;
			FUNC_SELECT_HIGH_OFS: return selHi;
			default: return READ_ZERO;
		endcase
	endfunction : regVal
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		regRdStb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		regAddr <= a;
		regWrStb <= 1'b0;
		regRdStb <= 1'b1;
		@(posedge clk);
		regRdStb <= 1'b0;
		#1 chk("read data", regRdData, regVal(a));
	endtask : rd
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk);
			regWrStb <= 1'b0;
			regRdStb <= 1'b0;
		end
	endtask : idle
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// Controller drive and pad input change every cycle
	always @(posedge clk) begin
		ctrlOut <= $random(seed);
		ctrlOeN <= $random(seed);
		padIn <= $random(seed);
	end
	// Reference state and pad checks; pads lag the registers by one edge
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			own = OWN_RST | ~MUX;
			selLo = '0;
			selHi = '0;
			up = 0;
		end else begin
			if (up > 0) chk("pad out", padOut, expOut);
			if (up > 0) chk("pad enable", padOeN, expOeN);
			if (up > 1) chk("peripheral in", periphIn, d2);
			d2 = d1;
			d1 = padIn;
			// Absent function leaves the pin undriven
			for (int p = 0; p < PIN_COUNT; p++) begin
				fc = {selHi[p], selLo[p]};
				expOut[p] = own[p] ? ctrlOut[p] : FMAP[p*4+fc] & periphOut[p*4+fc];
				expOeN[p] = own[p] ? ctrlOeN[p] : ~FMAP[p*4+fc] | periphOeN[p*4+fc];
			end
			if (regWrStb) begin
				case (regAddr)
					TAKEOVER_SET_OFS: own = own | (regWrData & MUX);
					RELEASE_CLEAR_OFS: own = own & ~(regWrData & MUX);
					FUNC_SELECT_LOW_OFS: selLo = regWrData;
					FUNC_SELECT_HIGH_OFS: selHi = regWrData;
					default: ;
				endcase
			end
			up = up + 1;
		end
	end
	// Hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#40000;
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		// Reset values, write-only words and one unmapped word
		for (int a = 0; a <= 20; a += 4) rd(8'(a));
		// Every function code handed to the peripherals, then half taken back
		for (int f = 0; f < FUNC_COUNT; f++) begin
			wr(FUNC_SELECT_LOW_OFS, f[0] ? 32'hFFFFFFFF : 32'h0);
			rd(FUNC_SELECT_LOW_OFS);
			wr(FUNC_SELECT_HIGH_OFS, f[1] ? 32'hFFFFFFFF : 32'h0);
			wr(RELEASE_CLEAR_OFS, 32'hFFFFFFFF);
			rd(OWNERSHIP_STATUS_OFS);
			idle(6);
			wr(TAKEOVER_SET_OFS, 32'h8000FFFF);
			rd(OWNERSHIP_STATUS_OFS);
		end
		// Random back-to-back traffic, unmapped words included
		repeat (300) begin
			ra = {3'h0, 3'($unsigned($random(seed)) % 7), 2'h0};
			rv = $random(seed);
			if (rv[0]) wr(ra, $random(seed));
			else rd(ra);
		end
		idle(3);
		stop_test();
	end
endmodule : test_io_line_function_mux
